// ### uef_fifo_if.sv
// Purpose: Link between the flag controller and the receive FIFO
// Assumes: Push and pop are single-cycle strobes on core_clk
// Notes: head_data is valid whenever empty is low
`timescale 1ns/1ps

interface uef_fifo_if;
   import uef_pkg::*;
   logic push;
   logic [DATA_W-1:0] push_data;
   logic pop;
   logic [DATA_W-1:0] head_data;
   logic empty;
   logic full;
   modport ctrl(output push, output push_data, output pop,
                input head_data, input empty, input full);
   modport fifo(input push, input push_data, input pop,
                output head_data, output empty, output full);
endinterface

// ### uef_flags.sv
// Purpose: Transmit-done and receive-ready event flags, data buffer paths, interrupt request
// Assumes: Shifter and baud logic give stop-bit strobes; all inputs synchronous to core_clk
// Notes: Flags are cleared only by software writes of zero
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module uef_flags import uef_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic uart_int_en,
   input wire logic sw_flag_we,
   input wire logic [FLAG_W-1:0] sw_flag_wdata,
   input wire logic sbuf_wr,
   input wire logic [DATA_W-1:0] sbuf_wdata,
   input wire logic sbuf_rd,
   input wire logic tx_stop_begin,
   input wire logic rx_stop_sample,
   input wire logic [DATA_W-1:0] rx_byte,
   output logic tx_done_flag,
   output logic rx_ready_flag,
   output logic uart_irq,
   output logic [DATA_W-1:0] serial_data_buffer,
   output logic [DATA_W-1:0] tx_shift_data,
   output logic tx_start,
   output logic rx_overrun
);
   logic tx_done_r;
   logic tx_done_nxt;
   logic rx_ready_r;
   logic rx_ready_nxt;
   logic irq_r;
   logic [DATA_W-1:0] rx_latch_r;
   logic [DATA_W-1:0] tx_shift_r;
   logic tx_start_r;
   logic rx_overrun_r;
   uef_latch_type latch_r;
   uef_latch_type latch_nxt;

   uef_fifo_if fif();

   uef_rx_fifo u_rx_fifo (
      .core_clk(core_clk),
      .resetn(resetn),
      .fif(fif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Flag decode
   wire tx_sw_clr = uef_sw_clears(sw_flag_we, sw_flag_wdata, TX_DONE_BIT);
   wire rx_sw_clr = uef_sw_clears(sw_flag_we, sw_flag_wdata, RX_READY_BIT);
   wire fifo_empty = fif.empty;
   wire fifo_full = fif.full;

   // Set term first, so a clear in the same cycle cannot hide the event
   assign tx_done_nxt = tx_stop_begin | (tx_done_r & ~tx_sw_clr);
   // Waiting bytes hold the flag up; a clear only lasts once the FIFO is empty
   assign rx_ready_nxt = rx_stop_sample | ~fifo_empty | (rx_ready_r & ~rx_sw_clr);

   // Interrupt is a level taken from next flag state, so it rises with the flag
   wire irq_nxt = uart_int_en & (tx_done_nxt | rx_ready_nxt);

   ////////////////////////////////////////////////////////////////////////////
   // Receive path: FIFO head moves into the latch when the latch is free
   wire latch_free = (latch_r == LATCH_EMPTY) | sbuf_rd;
   wire fifo_pop = latch_free & ~fifo_empty;

   assign fif.push = rx_stop_sample;
   assign fif.push_data = rx_byte;
   assign fif.pop = fifo_pop;

   always_comb begin
      case (latch_r)
         LATCH_EMPTY: begin
            latch_nxt = fifo_pop ? LATCH_FULL : LATCH_EMPTY;
         end
         LATCH_FULL: begin
            latch_nxt = (sbuf_rd && !fifo_pop) ? LATCH_EMPTY : LATCH_FULL;
         end
         default: begin
            latch_nxt = LATCH_EMPTY;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag and interrupt registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_done_r <= FLAG_RESET;
         rx_ready_r <= FLAG_RESET;
         irq_r <= FLAG_RESET;
      end else begin
         tx_done_r <= tx_done_nxt;
         rx_ready_r <= rx_ready_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Receive latch and overrun strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         latch_r <= LATCH_EMPTY;
         rx_latch_r <= SBUF_RESET;
         rx_overrun_r <= FLAG_RESET;
      end else begin
         latch_r <= latch_nxt;
         rx_latch_r <= fifo_pop ? fif.head_data : rx_latch_r;
         // A byte arriving into a full FIFO is dropped; the strobe tells software
         rx_overrun_r <= rx_stop_sample & fifo_full;
      end
   end

   // Transmit side: a buffer write loads the shifter and kicks off a frame
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_shift_r <= SBUF_RESET;
         tx_start_r <= FLAG_RESET;
      end else begin
         tx_shift_r <= sbuf_wr ? sbuf_wdata : tx_shift_r;
         tx_start_r <= sbuf_wr;
      end
   end

   assign tx_done_flag = tx_done_r;
   assign rx_ready_flag = rx_ready_r;
   assign uart_irq = irq_r;
   assign serial_data_buffer = rx_latch_r;
   assign tx_shift_data = tx_shift_r;
   assign tx_start = tx_start_r;
   assign rx_overrun = rx_overrun_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   tx_done_set_a: assert property (tx_stop_begin |=> tx_done_flag)
      else $error("transmit-done not set after stop bit start");

   rx_ready_set_a: assert property (rx_stop_sample |=> rx_ready_flag)
      else $error("receive-ready not set after stop bit sample");

   irq_request_a: assert property (
      (uart_int_en && (tx_stop_begin || rx_stop_sample)) |=> uart_irq && (tx_done_flag || rx_ready_flag))
      else $error("interrupt not requested for set flag");

   rx_hold_a: assert property ((!fifo_empty && rx_sw_clr) |=> rx_ready_flag)
      else $error("receive-ready dropped while FIFO holds data");

   rx_clear_a: assert property (
      (fifo_empty && rx_sw_clr && !rx_stop_sample) |=> !rx_ready_flag)
      else $error("receive-ready clear ignored with FIFO empty");

   tx_load_a: assert property (
      sbuf_wr |=> tx_start && (tx_shift_data == $past(sbuf_wdata))
         ##1 (!tx_start || $past(sbuf_wr)))
      else $error("buffer write did not load and start transmit");

   latch_load_a: assert property (
      (rx_stop_sample && fifo_empty && latch_r == LATCH_EMPTY && !fifo_full)
         |=> ##1 (serial_data_buffer == $past(rx_byte, 2)) && latch_r == LATCH_FULL)
      else $error("received byte not moved into receive latch");

   set_wins_a: assert property (
      (rx_stop_sample && rx_sw_clr) |=> rx_ready_flag)
      else $error("software clear overrode receive-ready set");

   tx_set_wins_a: assert property (
      (tx_stop_begin && tx_sw_clr) |=> tx_done_flag)
      else $error("software clear overrode transmit-done set");

   // Flags only fall on a software clear
   tx_keep_a: assert property (
      (tx_done_flag && !tx_sw_clr) |=> tx_done_flag)
      else $error("transmit-done dropped without a software clear");

   rx_keep_a: assert property (
      (rx_ready_flag && !rx_sw_clr) |=> rx_ready_flag)
      else $error("receive-ready dropped without a software clear");

   tx_clear_a: assert property (
      (tx_sw_clr && !tx_stop_begin) |=> !tx_done_flag)
      else $error("transmit-done clear ignored");

   fifo_hold_a: assert property (
      !fifo_empty |=> rx_ready_flag)
      else $error("receive-ready low while FIFO holds data");

   irq_level_a: assert property (
      uart_irq == ($past(uart_int_en) && (tx_done_flag || rx_ready_flag)))
      else $error("interrupt request does not follow flags and enable");

   // Receive latch moves only when its slot is free
   latch_hold_a: assert property (
      (latch_r == LATCH_FULL && !sbuf_rd) |=> $stable(serial_data_buffer))
      else $error("receive latch changed while full and unread");

   latch_read_a: assert property (
      (sbuf_rd && !fifo_empty) |=> (serial_data_buffer == $past(fif.head_data)))
      else $error("read did not reload receive latch from FIFO head");

   latch_fill_a: assert property (
      (latch_r == LATCH_EMPTY && !fifo_empty) |=> latch_r == LATCH_FULL)
      else $error("empty receive latch not filled from FIFO");

   tx_data_hold_a: assert property (
      !sbuf_wr |=> $stable(tx_shift_data))
      else $error("transmit data changed without a buffer write");

   tx_start_a: assert property (
      tx_start == $past(sbuf_wr))
      else $error("transmit start not a one-cycle echo of buffer write");

   overrun_flag_a: assert property (
      rx_overrun == $past(rx_stop_sample && fifo_full))
      else $error("overrun strobe does not match dropped byte");
endmodule

// ### uef_flags_tb_top.sv
// Purpose: Self-checking bench for the serial port event flags
// Assumes: Inputs change on the falling edge, outputs checked there
// Notes: Stop strobe timing follows tx_gap in the partner model
`timescale 1ns/1ps

module uef_flags_tb_top import uef_pkg::*;;
   logic core_clk = 1'b0, resetn = 1'b0, uart_int_en = 1'b1;
   logic sw_flag_we = 1'b0, sbuf_wr = 1'b0, sbuf_rd = 1'b0;
   logic [FLAG_W-1:0] sw_flag_wdata = 2'h3;
   logic [DATA_W-1:0] sbuf_wdata = 8'h00, rx_byte, serial_data_buffer, tx_shift_data;
   logic tx_stop_begin, rx_stop_sample, tx_done_flag, rx_ready_flag, uart_irq;
   logic tx_start, rx_overrun;
   logic [3:0] tx_gap = 4'h8;
   int n_fail = 0, tests_run = 0, cyc = 0;

   always #50 core_clk = ~core_clk;

   uef_flags uef_flags_inst (.core_clk, .resetn, .uart_int_en, .sw_flag_we, .sw_flag_wdata,
      .sbuf_wr, .sbuf_wdata, .sbuf_rd, .tx_stop_begin, .rx_stop_sample, .rx_byte,
      .tx_done_flag, .rx_ready_flag, .uart_irq, .serial_data_buffer, .tx_shift_data,
      .tx_start, .rx_overrun);
   uef_remote_model uef_remote_model_inst (.core_clk, .resetn, .tx_start, .tx_gap,
      .tx_stop_begin, .rx_stop_sample, .rx_byte);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic sw_pulse(input logic [FLAG_W-1:0] w);
      @(negedge core_clk);
      sw_flag_we = 1'b1;
      sw_flag_wdata = w;
      @(negedge core_clk);
      sw_flag_we = 1'b0;
   endtask

   task automatic rd();
      @(negedge core_clk);
      sbuf_rd = 1'b1;
      @(negedge core_clk);
      sbuf_rd = 1'b0;
      @(negedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_tx();
      int i;
      @(negedge core_clk);
      sbuf_wr = 1'b1;
      sbuf_wdata = 8'hC3;
      @(negedge core_clk);
      sbuf_wr = 1'b0;
      chk({7'h00, tx_start}, 8'h01);
      chk(tx_shift_data, 8'hC3);
      @(negedge core_clk);
      chk({7'h00, tx_start}, 8'h00);
      chk({7'h00, tx_done_flag}, 8'h00);
      for (i = 0; i < 20 && tx_done_flag !== 1'b1; i++) @(negedge core_clk);
      chk({7'h00, tx_done_flag}, 8'h01);
      chk({7'h00, uart_irq}, 8'h01);
      repeat (10) @(negedge core_clk);
      chk({7'h00, tx_done_flag}, 8'h01);
      sw_pulse(2'h1);
      chk({7'h00, tx_done_flag}, 8'h00);
      chk({7'h00, uart_irq}, 8'h00);
      $display("test tx done");
   endtask

   task automatic t_rx();
      int i;
      for (i = 0; i < 3; i++) uef_remote_model_inst.send(8'hA0 + 8'(i));
      repeat (3) @(negedge core_clk);
      chk({7'h00, rx_ready_flag}, 8'h01);
      chk(serial_data_buffer, 8'hA0);
      sw_pulse(2'h2);
      @(negedge core_clk);
      chk({7'h00, rx_ready_flag}, 8'h01);
      for (i = 1; i < 3; i++) begin
         rd();
         chk(serial_data_buffer, 8'hA0 + 8'(i));
      end
      sw_pulse(2'h2);
      chk({7'h00, rx_ready_flag}, 8'h00);
      $display("test rx done");
   endtask

   // Clear lands on the same edge as a new byte, with the interrupt masked
   task automatic t_race();
      uart_int_en = 1'b0;
      fork
         uef_remote_model_inst.send(8'h5A);
         sw_pulse(2'h2);
      join
      chk({7'h00, rx_ready_flag}, 8'h01);
      chk({7'h00, uart_irq}, 8'h00);
      chk(serial_data_buffer, 8'hA2);
      rd();
      chk(serial_data_buffer, 8'h5A);
      // Stop strobe comes tx_gap + 1 falling edges after the buffer write
      @(negedge core_clk);
      sbuf_wr = 1'b1;
      sbuf_wdata = 8'h3C;
      @(negedge core_clk);
      sbuf_wr = 1'b0;
      repeat (int'(tx_gap) - 1) @(negedge core_clk);
      sw_pulse(2'h1);
      chk({7'h00, tx_done_flag}, 8'h01);
      $display("test race done");
   endtask

   // Four bytes fill the FIFO behind a full latch; the fifth is dropped
   task automatic t_ovr();
      int i;
      uart_int_en = 1'b1;
      for (i = 0; i < 5; i++) uef_remote_model_inst.send(8'hB0 + 8'(i));
      chk({7'h00, rx_overrun}, 8'h01);
      chk({7'h00, uart_irq}, 8'h01);
      @(negedge core_clk);
      chk({7'h00, rx_overrun}, 8'h00);
      for (i = 0; i < 4; i++) begin
         rd();
         chk(serial_data_buffer, 8'hB0 + 8'(i));
      end
      rd();
      chk(serial_data_buffer, 8'hB3);
      sw_pulse(2'h2);
      chk({7'h00, rx_ready_flag}, 8'h00);
      $display("test overrun done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         results();
      end
   end

   initial begin
      repeat (20) @(negedge core_clk);
      resetn = 1'b1;
      t_tx();
      t_rx();
      t_race();
      t_ovr();
      results();
   end
endmodule

// ### uef_pkg.sv
// Purpose: Shared constants and types for the serial port event flag block
// Assumes: One 10 MHz core clock, flags and data buffer reached by plain strobes
// Notes: Flag bit positions match the serial control register layout

package uef_pkg;
   localparam int DATA_W = 8;
   localparam int FLAG_W = 2;
   localparam int TX_DONE_BIT = 1;
   localparam int RX_READY_BIT = 0;
   localparam int RX_FIFO_DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int CNT_W = 3;
   localparam logic [DATA_W-1:0] SBUF_RESET = 8'h00;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
   localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;

   typedef enum logic {LATCH_EMPTY, LATCH_FULL} uef_latch_type;

   // True when a software write puts zero into the given flag bit
   function automatic logic uef_sw_clears(input logic we, input logic [FLAG_W-1:0] wdata,
                                          input int bit_pos);
      return we & ~wdata[bit_pos];
   endfunction
endpackage

// ### uef_remote_model.sv
// Purpose: Far side of the serial line, seen as shifter strobes
// Assumes: Drives on the falling edge of core_clk
// Notes: tx_gap sets how slowly the stop bit follows tx_start
`timescale 1ns/1ps

module uef_remote_model import uef_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic tx_start,
   input wire logic [3:0] tx_gap,
   output logic tx_stop_begin,
   output logic rx_stop_sample,
   output logic [DATA_W-1:0] rx_byte
);
   logic [3:0] cnt;

   initial begin
      tx_stop_begin = 1'b0;
      rx_stop_sample = 1'b0;
      rx_byte = 8'h00;
      cnt = 4'h0;
   end

   // Stop bit starts a number of cycles after the character is launched
   always @(negedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 4'h0;
         tx_stop_begin <= 1'b0;
      end else begin
         tx_stop_begin <= (cnt == 4'h1);
         if (cnt != 4'h0) cnt <= cnt - 4'h1;
         if (tx_start) cnt <= tx_gap;
      end
   end

   // Byte is only valid with its strobe; afterwards the lines show junk
   task automatic send(input logic [DATA_W-1:0] b);
      @(negedge core_clk);
      rx_stop_sample = 1'b1;
      rx_byte = b;
      @(negedge core_clk);
      rx_stop_sample = 1'b0;
      rx_byte = ~b;
   endtask
endmodule

// ### uef_rx_fifo.sv
// Purpose: Receive FIFO holding bytes until the receive latch is free
// Assumes: Push when full and pop when empty are ignored
// Notes: Depth fixed by package constant
`timescale 1ns/1ps

module uef_rx_fifo import uef_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   uef_fifo_if.fifo fif
);
   logic [DATA_W-1:0] mem_r [RX_FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   wire do_push = fif.push & ~fif.full;
   wire do_pop = fif.pop & ~fif.empty;

   assign fif.empty = (count_r == CNT_ZERO);
   assign fif.full = (count_r == CNT_FULL);
   assign fif.head_data = mem_r[rd_ptr_r];
   assign count_nxt = (do_push && !do_pop) ? count_r + CNT_ONE :
                      (do_pop && !do_push) ? count_r - CNT_ONE : count_r;

   ////////////////////////////////////////////////////////////////////////////
   // Storage has no reset; reads are gated by empty
   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= fif.push_data;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_r <= PTR_RESET;
         rd_ptr_r <= PTR_RESET;
         count_r <= CNT_ZERO;
      end else begin
         wr_ptr_r <= do_push ? wr_ptr_r + PTR_ONE : wr_ptr_r;
         rd_ptr_r <= do_pop ? rd_ptr_r + PTR_ONE : rd_ptr_r;
         count_r <= count_nxt;
      end
   end
endmodule
